/* File: uotg_pkg.sv */
// Package: register map, field positions, reset values and timing counts
package uotg_pkg;

  // ==========================================================
  // Register offsets (base word of each register)
  localparam logic [7:0] OFS_FLAGS   = 8'h00;
  localparam logic [7:0] OFS_ENABLES = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h20;
  localparam logic [7:0] OFS_CONTROL = 8'h30;
  localparam logic [7:0] OFS_POWER   = 8'h40;

  // Companion alias sub-offsets
  localparam logic [1:0] SUB_PLAIN = 2'h0;
  localparam logic [1:0] SUB_CLR   = 2'h1;
  localparam logic [1:0] SUB_SET   = 2'h2;
  localparam logic [1:0] SUB_INV   = 2'h3;

  // ==========================================================
  // Flag and enable field positions
  localparam int unsigned BIT_ID_CHG   = 7;
  localparam int unsigned BIT_MS_TICK  = 6;
  localparam int unsigned BIT_LINE_CHG = 5;
  localparam int unsigned BIT_ACT      = 4;
  localparam int unsigned BIT_SESV_CHG = 3;
  localparam int unsigned BIT_SESE_CHG = 2;
  localparam int unsigned BIT_VBUS_CHG = 0;
  localparam logic [7:0] FLAG_MASK     = 8'hFD;

  // Live status positions
  localparam logic [7:0] STATUS_MASK = 8'hAD;

  // Control field positions
  localparam int unsigned BIT_DP_PU   = 7;
  localparam int unsigned BIT_DM_PU   = 6;
  localparam int unsigned BIT_DP_PD   = 5;
  localparam int unsigned BIT_DM_PD   = 4;
  localparam int unsigned BIT_VBUS_ON = 3;
  localparam int unsigned BIT_PULL_SW = 2;
  localparam int unsigned BIT_VB_CHG  = 1;
  localparam int unsigned BIT_VB_DIS  = 0;

  // Power field positions
  localparam int unsigned BIT_ACT_PND = 7;
  localparam int unsigned BIT_SLP_GRD = 4;
  localparam int unsigned BIT_BUSY    = 3;
  localparam int unsigned BIT_SUSPEND = 1;
  localparam int unsigned BIT_PWR_ON  = 0;
  localparam logic [7:0] POWER_WMASK  = 8'h13;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_POWER   = 8'h00;

  // ==========================================================
  // Timing: clock rate and 1 ms timebase
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYCLES  = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned BUSY_CYCLES  = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Line and VBUS inputs grouped
  typedef struct packed {
    logic cable_id;
    logic se0;
    logic j_state_ind;
    logic sess_valid;
    logic sess_end;
    logic vbus_valid;
    logic bus_wake;
  } uotg_line_t;

  // Pull resistor group
  typedef struct packed {
    logic dp_pu;
    logic dm_pu;
    logic dp_pd;
    logic dm_pd;
  } uotg_pull_t;

endpackage

/* File: uotg_ctrl.sv */
// OTG supervision, line and VBUS control and module power with AXI4-Lite access
// Operation
// - Flags set by hardware; written one clears; written zero keeps.
// - Bit 7 sets when sampled cable identity changes.
// - Bit 6 sets whenever the 1 ms timer expires.
// - Bit 5 sets when line state settles 1 ms and differs.
// - Bit 4 sets when bus activity wakes the device.
// - Bit 3 sets when VBUS falls below session end.
// - Bit 2 sets on any session end comparator transition.
// - Bit 0 sets on session valid transition; bit 1 unimplemented.
// - Enable register, one bit per flag, resets disabled.
// - Bits 31-8 and unimplemented bits read zero, ignore writes.
// - Status bit 7 shows identity pin: one means no or B cable.
// - Status bit 5 one only if line indications stable for 1 ms.
// - Status bits 3, 2, 0 show session valid, end, VBUS valid.
// - Control bits 7-4 enable D+/D- pull-ups and pull-downs.
// - Control bit 2 selects software or hardware pull control.
// - Control bits 3, 1, 0 drive VBUS power, charge, discharge.
// - Power bit 7 shows activity detected, interrupt not raised.
// - Power bit 4 blocks sleep on activity or pending notice.
// - Power bit 3 busy while active or not yet re-enableable.
// - Power bit 1 suspends: gates 48 MHz clock, transceiver low power.
// - Power bit 0 low keeps module off; pulls, VBUS and clock inactive.
// - Offsets 0x4, 0x8, 0xC clear, set, invert written ones; for flags, 0x8 has no effect and 0xC clears.
`timescale 1ns/1ns
module uotg_ctrl
  import uotg_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter int unsigned BUSY_LEN = BUSY_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire uotg_line_t  line_i,
  input  wire uotg_pull_t  hw_pull_i,
  input  wire logic        core_active_i,
  output uotg_pull_t       pull_o,
  output logic             vbus_power_on_o,
  output logic             vbus_charge_en_o,
  output logic             vbus_discharge_en_o,
  output logic             usb_clk_en_o,
  output logic             xcvr_low_power_o,
  output logic             module_power_on_o,
  output logic             sleep_block_o,
  output logic             otg_irq_o
);
  // ==========================================================
  // Register state
  logic [7:0]  otg_event_flags, otg_event_enables, otg_line_vbus_control;
  logic [7:0]  power_sw, otg_live_status, usb_power_control, flag_set;
  logic [15:0] tick_cnt, stable_cnt;
  logic [1:0]  line_prev, settled_prev;
  logic        tick, line_settled_state, id_prev, sese_prev, vbv_prev;
  logic        activity_irq_pending, module_busy_ind;
  logic [7:0]  busy_cnt;
  // AXI write channel holding
  logic        aw_held, w_held, wr_go, wr_hit;
  logic [7:0]  aw_addr, wr_val, wr_reg;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [1:0]  wr_sub;
  // ==========================================================
  // 1 ms timebase
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (tick_cnt == 16'(TICK_LEN - 1)) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end
  // Line state stability tracker
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_prev          <= 2'h0;
      stable_cnt         <= 16'h0000;
      line_settled_state <= 1'b0;
      settled_prev       <= 2'h0;
    end else begin
      line_prev <= {line_i.se0, line_i.j_state_ind};
      if ({line_i.se0, line_i.j_state_ind} != line_prev) begin
        stable_cnt         <= 16'h0000;
        line_settled_state <= 1'b0;
      end else if (stable_cnt != 16'(TICK_LEN - 1)) begin
        stable_cnt <= stable_cnt + 16'h0001;
      end else begin
        // stable for the previous 1 ms
        line_settled_state <= 1'b1;
        if (!line_settled_state) begin
          settled_prev <= line_prev;
        end
      end
    end
  end
  // Previous comparator and identity samples
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      id_prev   <= 1'b1;
      sese_prev <= 1'b0;
      vbv_prev  <= 1'b0;
    end else begin
      id_prev   <= line_i.cable_id;
      sese_prev <= line_i.sess_end;
      vbv_prev  <= line_i.sess_valid;
    end
  end
  // ==========================================================
  // Event detection
  always_comb begin
    flag_set = 8'h00;
    flag_set[BIT_ID_CHG] = line_i.cable_id != id_prev;
    flag_set[BIT_MS_TICK] = tick;
    // settled line state differs from last settled state
    flag_set[BIT_LINE_CHG] = !line_settled_state && line_prev == {line_i.se0, line_i.j_state_ind}
                             && stable_cnt == 16'(TICK_LEN - 1) && line_prev != settled_prev;
    flag_set[BIT_ACT] = line_i.bus_wake;
    flag_set[BIT_SESV_CHG] = line_i.sess_end && !sese_prev;
    flag_set[BIT_SESE_CHG] = line_i.sess_end != sese_prev;
    flag_set[BIT_VBUS_CHG] = line_i.sess_valid != vbv_prev;
  end
  // ==========================================================
  // AXI write address and data capture
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  assign wr_go  = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_reg = {aw_addr[7:4], 4'h0};
  assign wr_sub = aw_addr[3:2];
  assign wr_val = w_strb[0] ? w_data[7:0] : 8'h00;
  assign wr_hit = wr_reg == OFS_FLAGS || wr_reg == OFS_ENABLES || wr_reg == OFS_STATUS
                  || wr_reg == OFS_CONTROL || wr_reg == OFS_POWER;
  // Write response
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end
  // Generic alias update: plain, clear, set, invert
  function automatic logic [7:0] apply_wr(input logic [7:0] cur, input logic [7:0] val,
                                          input logic [1:0] sub, input logic [7:0] msk);
    logic [7:0] res;
    res = cur;
    case (sub)
      SUB_PLAIN: res = val;
      SUB_CLR:   res = cur & ~val;
      SUB_SET:   res = cur | val;
      default:   res = cur ^ val;
    endcase
    return res & msk;
  endfunction
  // ==========================================================
  // Event flags: set wins over clear
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      otg_event_flags <= RST_FLAGS;
    end else begin
      if (wr_go && wr_reg == OFS_FLAGS && wr_sub != SUB_SET) begin
        otg_event_flags <= ((otg_event_flags & ~wr_val) | flag_set) & FLAG_MASK;
      end else begin
        otg_event_flags <= (otg_event_flags | flag_set) & FLAG_MASK;
      end
    end
  end
  // Enables, control and power software bits
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      otg_event_enables     <= RST_ENABLES;
      otg_line_vbus_control <= RST_CONTROL;
      power_sw              <= RST_POWER;
    end else if (wr_go) begin
      if (wr_reg == OFS_ENABLES) begin
        otg_event_enables <= apply_wr(otg_event_enables, wr_val, wr_sub, FLAG_MASK);
      end else if (wr_reg == OFS_CONTROL) begin
        otg_line_vbus_control <= apply_wr(otg_line_vbus_control, wr_val, wr_sub, 8'hFF);
      end else if (wr_reg == OFS_POWER) begin
        power_sw <= apply_wr(power_sw, wr_val, wr_sub, POWER_WMASK);
      end
    end
  end
  // ==========================================================
  // Activity pending and busy tracking
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      activity_irq_pending <= 1'b0;
    end else begin
      // activity seen, interrupt not yet raised
      activity_irq_pending <= line_i.bus_wake && !otg_event_flags[BIT_ACT];
    end
  end
  // Busy countdown after power-off
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_cnt        <= 8'h00;
      module_busy_ind <= 1'b0;
    end else begin
      // busy while on or winding down
      if (power_sw[BIT_PWR_ON] || core_active_i) begin
        busy_cnt        <= 8'(BUSY_LEN);
        module_busy_ind <= 1'b1;
      end else if (busy_cnt != 8'h00) begin
        busy_cnt        <= busy_cnt - 8'h01;
        module_busy_ind <= 1'b1;
      end else begin
        module_busy_ind <= 1'b0;
      end
    end
  end
  // Live status and power readback
  always_comb begin
    otg_live_status = 8'h00;
    otg_live_status[7] = line_i.cable_id;
    otg_live_status[5] = line_settled_state;
    otg_live_status[3] = line_i.sess_valid;
    otg_live_status[2] = line_i.sess_end;
    otg_live_status[0] = line_i.vbus_valid;
    usb_power_control = power_sw;
    usb_power_control[BIT_ACT_PND] = activity_irq_pending;
    usb_power_control[BIT_BUSY]    = module_busy_ind;
  end
  // ==========================================================
  // AXI read channel
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= RESP_OKAY;
      if (s_axi_araddr_i[7:2] == OFS_FLAGS[7:2]) begin
        s_axi_rdata_o <= {24'h000000, otg_event_flags};
      end else if (s_axi_araddr_i[7:2] == OFS_ENABLES[7:2]) begin
        s_axi_rdata_o <= {24'h000000, otg_event_enables};
      end else if (s_axi_araddr_i[7:2] == OFS_STATUS[7:2]) begin
        s_axi_rdata_o <= {24'h000000, otg_live_status & STATUS_MASK};
      end else if (s_axi_araddr_i[7:2] == OFS_CONTROL[7:2]) begin
        s_axi_rdata_o <= {24'h000000, otg_line_vbus_control};
      end else if (s_axi_araddr_i[7:2] == OFS_POWER[7:2]) begin
        s_axi_rdata_o <= {24'h000000, usb_power_control};
      end else begin
        s_axi_rdata_o <= 32'h0000_0000;
        s_axi_rresp_o <= RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
  // Read address ready while no read pending
  assign s_axi_arready_o = !s_axi_rvalid_o;
  // ==========================================================
  // Pin and power outputs, all registered
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pull_o              <= '0;
      vbus_power_on_o     <= 1'b0;
      vbus_charge_en_o    <= 1'b0;
      vbus_discharge_en_o <= 1'b0;
      usb_clk_en_o        <= 1'b0;
      xcvr_low_power_o    <= 1'b1;
      module_power_on_o   <= 1'b0;
      sleep_block_o       <= 1'b0;
    end else begin
      // pulls and VBUS outputs inactive while module is off
      module_power_on_o <= power_sw[BIT_PWR_ON];
      if (!power_sw[BIT_PWR_ON]) begin
        pull_o              <= '0;
        vbus_power_on_o     <= 1'b0;
        vbus_charge_en_o    <= 1'b0;
        vbus_discharge_en_o <= 1'b0;
      end else begin
        // pull enables, software or hardware source
        if (otg_line_vbus_control[BIT_PULL_SW]) begin
          pull_o <= otg_line_vbus_control[7:4];
        end else begin
          pull_o <= hw_pull_i;
        end
        vbus_power_on_o     <= otg_line_vbus_control[BIT_VBUS_ON];
        vbus_charge_en_o    <= otg_line_vbus_control[BIT_VB_CHG];
        vbus_discharge_en_o <= otg_line_vbus_control[BIT_VB_DIS];
      end
      // suspend gates the 48 MHz clock
      usb_clk_en_o     <= power_sw[BIT_PWR_ON] && !power_sw[BIT_SUSPEND];
      xcvr_low_power_o <= !power_sw[BIT_PWR_ON] || power_sw[BIT_SUSPEND];
      sleep_block_o <= power_sw[BIT_SLP_GRD]
                       && (line_i.bus_wake || activity_irq_pending);
    end
  end
  // Interrupt request
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      otg_irq_o <= 1'b0;
    end else begin
      otg_irq_o <= |(otg_event_flags & otg_event_enables);
    end
  end
  // ==========================================================
  // Checks
  // flag survives zero writes
  flag_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    otg_event_flags[BIT_MS_TICK] && !(wr_go && wr_reg == OFS_FLAGS && wr_val[BIT_MS_TICK])
    |=> otg_event_flags[BIT_MS_TICK])
    else $error("flag lost without clear");
  id_change_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    line_i.cable_id != id_prev |=> otg_event_flags[BIT_ID_CHG])
    else $error("identity change missed");
  tick_flag_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    tick |=> otg_event_flags[BIT_MS_TICK])
    else $error("tick flag missed");
  sese_flag_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $changed(line_i.sess_end) |-> ##1 otg_event_flags[BIT_SESE_CHG])
    else $error("session end change missed");
  bit1_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !otg_event_flags[1] && !otg_event_enables[1])
    else $error("unimplemented bit set");
  power_off_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !power_sw[BIT_PWR_ON] |=> pull_o == '0 && !vbus_power_on_o)
    else $error("outputs active while off");
  suspend_gate_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    power_sw[BIT_SUSPEND] |=> !usb_clk_en_o && xcvr_low_power_o)
    else $error("clock not gated in suspend");
  irq_follow_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ##1 otg_irq_o == $past(|(otg_event_flags & otg_event_enables)))
    else $error("interrupt mismatch");
endmodule

/* File: uotg_peer_model.sv */
// Cable peer model: identity pin, line state, VBUS comparators and wake
`timescale 1ns/1ns
module uotg_peer_model
  import uotg_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic [1:0] vlvl_i,
  input  wire logic [3:0] cmd_i,
  input  wire logic       vbus_power_on_i,
  output uotg_line_t      line_o
);
  logic [1:0] lvl;
  // Supply drives full level when VBUS power is requested
  assign lvl = vbus_power_on_i ? 2'h3 : vlvl_i;
  // Pins and comparators move just after the clock edge
  always_ff @(posedge mclk_i) begin
    line_o <= {cmd_i[3:1], lvl >= 2'h2, lvl == 2'h0, lvl == 2'h3, cmd_i[0]};
  end
endmodule

/* File: usb_otg_status_power_ctrl_tb.sv */
// Self-checking bench for the OTG status and power control block
`timescale 1ns/1ns
module usb_otg_status_power_ctrl_tb;
  import uotg_pkg::*;
  localparam int unsigned TL = 20;
  logic        mclk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, core_act = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd, d, e;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp, sb;
  logic [1:0]  vlvl = 2'h3;
  logic [3:0]  cmd = 4'h8;
  uotg_line_t  line;
  uotg_pull_t  hw_pull = 4'h0;
  uotg_pull_t  pull;
  logic        vb_on, vb_chg, vb_dis, clk_en, lowpwr, pwr_on, slp_blk, irq;
  int          error_cnt = 0;
  int          total_checks = 0;

  // ========
  // Clock, design and far-side model
  always #25 mclk_i = ~mclk_i;
  uotg_ctrl #(.TICK_LEN(TL), .BUSY_LEN(BUSY_CYCLES)) i_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .line_i(line), .hw_pull_i(hw_pull),
    .core_active_i(core_act), .pull_o(pull), .vbus_power_on_o(vb_on),
    .vbus_charge_en_o(vb_chg), .vbus_discharge_en_o(vb_dis), .usb_clk_en_o(clk_en),
    .xcvr_low_power_o(lowpwr), .module_power_on_o(pwr_on), .sleep_block_o(slp_blk),
    .otg_irq_o(irq)
  );
  uotg_peer_model i_peer (
    .mclk_i(mclk_i), .vlvl_i(vlvl), .cmd_i(cmd), .vbus_power_on_i(vb_on), .line_o(line)
  );

  // ========
  // Compare, bus and expectation helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge mclk_i);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge mclk_i);
      aw_d |= awvalid & awready;
      w_d |= wvalid & wready;
      if (aw_d) awvalid <= 1'b0;
      if (w_d) wvalid <= 1'b0;
    end
    while (!bvalid) @(posedge mclk_i);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  // Read: data and response taken at the edge where rvalid is seen
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk_i); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge mclk_i);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(nm, rd, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // Register value after a plain, clear, set or invert access
  function automatic logic [31:0] alias_exp(logic [31:0] old, logic [31:0] dv, logic [1:0] s);
    case (s)
      SUB_CLR: return old & ~dv;
      SUB_SET: return old | dv;
      SUB_INV: return old ^ dv;
      default: return dv;
    endcase
  endfunction

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ========
  // Main sequence
  initial begin
    void'($urandom(87737));
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    rchk("enables reset", OFS_ENABLES, 32'h0);
    rchk("control reset", OFS_CONTROL, 32'h0);
    rd_reg(8'h50);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped rresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(8'h50, 32'hFF);
    chk("unmapped bresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Power on, guard on, not suspended
    wr(OFS_POWER, 32'h11);
    cyc(2);
    chk("power on", {30'h0, pwr_on, clk_en}, 32'h3);
    chk("xcvr awake", {31'h0, lowpwr}, 32'h0);
    rchk("power busy", OFS_POWER, 32'h19);
    // Enables through all four aliases, random data with upper bits set
    e = 32'h0;
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      sb = 2'(i);
      wr(OFS_ENABLES + {4'h0, sb, 2'h0}, d);
      chk("enables bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
      e = alias_exp(e, d, sb) & {24'h0, FLAG_MASK};
      rchk("enables", OFS_ENABLES, e);
      chk("enables rresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    end
    // Control with random pull source and VBUS bits
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      hw_pull <= uotg_pull_t'(4'($urandom));
      wr(OFS_CONTROL, d);
      cyc(2);
      chk("pull", 32'(pull), 32'(d[2] ? d[7:4] : 4'(hw_pull)));
      chk("vbus ctl", {29'h0, vb_on, vb_chg, vb_dis}, {29'h0, d[3], d[1:0]});
      rchk("control", OFS_CONTROL, d & 32'hFF);
    end
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_ENABLES, 32'h0);
    // Cable identity change, zero write keeps, one write clears
    cmd <= 4'h0;
    cyc(3);
    rd_reg(OFS_FLAGS);
    chk("id flag", {31'h0, rd[7]}, 32'h1);
    wr(OFS_FLAGS, 32'h0);
    rd_reg(OFS_FLAGS);
    chk("id flag kept", {31'h0, rd[7]}, 32'h1);
    wr(OFS_FLAGS, 32'h80);
    rd_reg(OFS_FLAGS);
    chk("id flag cleared", {31'h0, rd[7]}, 32'h0);
    // VBUS drop below session end
    wr(OFS_FLAGS, 32'hFF);
    vlvl <= 2'h0;
    cyc(3);
    rd_reg(OFS_FLAGS);
    chk("vbus flags", rd & 32'h0F, 32'h0D);
    rchk("status", OFS_STATUS, 32'h24);
    vlvl <= 2'h3;
    cyc(3);
    rd_reg(OFS_STATUS);
    chk("status vbus up", rd & 32'h8D, 32'h09);
    // Millisecond tick raises the request only when enabled
    wr(OFS_FLAGS, 32'hFF);
    wr(OFS_ENABLES, 32'h40);
    cyc(TL + 3);
    chk("tick irq", {31'h0, irq}, 32'h1);
    wr(OFS_ENABLES, 32'h0);
    cyc(2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    // Line settles on J, then an SE0 breaks stability
    wr(OFS_FLAGS, 32'hFF);
    cmd <= 4'h2;
    cyc(TL + 4);
    rd_reg(OFS_STATUS);
    chk("line stable", {31'h0, rd[5]}, 32'h1);
    rd_reg(OFS_FLAGS);
    chk("line flag", {31'h0, rd[5]}, 32'h1);
    cmd <= 4'h4;
    cyc(3);
    rd_reg(OFS_STATUS);
    chk("line unstable", {31'h0, rd[5]}, 32'h0);
    // Wake with the sleep guard set
    wr(OFS_FLAGS, 32'hFF);
    cmd <= 4'h5;
    cyc(3);
    chk("sleep block", {31'h0, slp_blk}, 32'h1);
    rd_reg(OFS_FLAGS);
    chk("activity flag", {31'h0, rd[4]}, 32'h1);
    cmd <= 4'h8;
    // Suspend, then off with the core still active
    wr(OFS_POWER, 32'h03);
    cyc(2);
    chk("suspend", {30'h0, clk_en, lowpwr}, 32'h1);
    chk("no guard", {31'h0, slp_blk}, 32'h0);
    core_act <= 1'b1;
    wr(OFS_POWER, 32'h00);
    cyc(BUSY_CYCLES + 4);
    chk("off", {31'h0, pwr_on}, 32'h0);
    rd_reg(OFS_POWER);
    chk("busy held", {31'h0, rd[3]}, 32'h1);
    core_act <= 1'b0;
    cyc(BUSY_CYCLES + 4);
    rchk("idle", OFS_POWER, 32'h0);
    test_done();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(50 * 20000);
    error_cnt++;
    test_done();
  end
endmodule
